//--- rtl/sms_pkg.sv
// Purpose: Shared constants and types for the serial port block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: Byte addresses inside a 4 KB window; upper address bits ignored
package sms_pkg;
    // Register byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_MASK = 12'h008;
    localparam logic [11:0] ADDR_DATA = 12'h00C;
    // Control field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MST_BIT = 1;
    localparam int CTRL_LSB_BIT = 2;
    localparam int CTRL_RATE_LSB = 4;
    // Status and mask field positions
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_COLL_BIT = 1;
    // Last bit index of a byte and slowest rate code
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] RATE_MAX = 3'h6;
    // Reset values
    localparam logic [2:0] RATE_RST = 3'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] SYNC_RST = 4'h8;

    // Engine phase
    typedef enum logic [1:0] {ST_IDLE, ST_MASTER, ST_SLAVE} sms_phase_t;

    // Serial pin drivers, enables active low
    typedef struct packed {
        logic sck_o;
        logic sck_oe_n;
        logic mosi_o;
        logic mosi_oe_n;
        logic miso_o;
        logic miso_oe_n;
    } sms_pins_t;

    // Whole block state
    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic sck_prev;
        sms_phase_t phase;
        logic [7:0] shreg;
        logic [7:0] rx_buf;
        logic [2:0] bitcnt;
        logic [6:0] divcnt;
        logic samp;
        logic enable;
        logic master;
        logic lsbf;
        logic [2:0] rate;
        logic [1:0] status;
        logic [1:0] mask;
        logic dp_sel;
        logic dp_wr;
        logic [11:0] dp_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
        logic irq;
        sms_pins_t pins;
    } sms_state_t;
endpackage

//--- rtl/sms_port.sv
// Purpose: Byte-wide master/slave synchronous serial port, AHB-Lite slave
// Assumes: One 100 MHz clock; serial pins synchronised on entry
// Notes: Clock idles low, data sampled on rising and shifted on falling
//
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns

// Functional notes
// - Master drives MOSI and SCK, slave MISO
// - Master role never drives select line
// - Data write in master starts eight bits
// - Clock halts, done flag set after byte
// - Done flag raises enabled interrupt request
// - Last received byte stays readable
// - Slave idle with MISO released when deselected
// - Slave shifts nothing while deselected
// - Slave sets done after full byte
// - Single transmit buffer, no mid-byte reload
// - Unread received byte overwritten by next
// - Enabled port overrides pin directions
// - Selectable LSB-first or MSB-first order
// - Seven bit rates, fastest divides by two
module sms_port (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    output logic irq_o,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe_n_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_n_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_n_o,
    input wire logic ss_n_i
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Bit presented on the data line for a given order
    function automatic logic out_bit(input logic [7:0] b, input logic lsbf);
        out_bit = lsbf ? b[0] : b[7];
    endfunction

    // Shift one received bit into the byte
    function automatic logic [7:0] shift_in(input logic [7:0] b, input logic lsbf,
                                            input logic d);
        shift_in = lsbf ? {d, b[7:1]} : {b[6:0], d};
    endfunction

    // Core cycles per half serial clock period
    function automatic logic [6:0] half_period(input logic [2:0] rate);
        logic [2:0] r;
        r = (rate > sms_pkg::RATE_MAX) ? sms_pkg::RATE_MAX : rate;
        half_period = 7'h01 << r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Reset release

    logic [1:0] rst_sync; // Two-stage release of the reset
    logic rst_n; // Synchronised reset used everywhere else

    // Asserts at once, releases after two edges
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    sms_pkg::sms_state_t s; // Current state
    sms_pkg::sms_state_t next_s; // Next state
    logic ss_n; // Synchronised select
    logic sck_in; // Synchronised serial clock
    logic mosi_in; // Synchronised slave data in
    logic miso_in; // Synchronised master data in
    logic sck_rise; // Serial clock rising edge seen
    logic sck_fall; // Serial clock falling edge seen
    logic wr_data; // Data-phase write to the data register
    logic done_ev; // Byte finished this cycle
    logic coll_ev; // Write refused this cycle

    // Synchronised pins come from the second stage only
    assign ss_n = s.sync2[3];
    assign sck_in = s.sync2[2];
    assign mosi_in = s.sync2[1];
    assign miso_in = s.sync2[0];
    assign sck_rise = sck_in && !s.sck_prev;
    assign sck_fall = !sck_in && s.sck_prev;
    assign wr_data = s.dp_sel && s.dp_wr && (s.dp_addr == sms_pkg::ADDR_DATA);

    // Bus slave, control registers, shift engine and flags
    always_comb begin
        logic [7:0] nb;
        logic [1:0] w1c;
        nb = sms_pkg::BYTE_RST;
        w1c = 2'h0;
        next_s = s;
        done_ev = 1'b0;
        coll_ev = 1'b0;
        // pins cross by two flops, hence quarter rate
        next_s.sync1 = {ss_n_i, sck_i, mosi_i, miso_i};
        next_s.sync2 = s.sync1;
        next_s.sck_prev = sck_in;
        next_s.hreadyout = 1'b1;
        next_s.hresp = 1'b0;

        // Address phase: capture and prepare read data
        next_s.dp_sel = 1'b0;
        if (hsel_i && hready_i && htrans_i[1]) begin
            next_s.dp_sel = 1'b1;
            next_s.dp_wr = hwrite_i;
            next_s.dp_addr = haddr_i[11:0];
            // Unmapped addresses read zero
            next_s.hrdata = 32'h0000_0000;
            unique case (haddr_i[11:0])
                sms_pkg::ADDR_CTRL: begin
                    next_s.hrdata[sms_pkg::CTRL_EN_BIT] = s.enable;
                    next_s.hrdata[sms_pkg::CTRL_MST_BIT] = s.master;
                    next_s.hrdata[sms_pkg::CTRL_LSB_BIT] = s.lsbf;
                    next_s.hrdata[sms_pkg::CTRL_RATE_LSB +: 3] = s.rate;
                end
                sms_pkg::ADDR_STATUS: next_s.hrdata[1:0] = s.status;
                sms_pkg::ADDR_MASK: next_s.hrdata[1:0] = s.mask;
                sms_pkg::ADDR_DATA: next_s.hrdata[7:0] = s.rx_buf;
                default: next_s.hrdata = 32'h0000_0000;
            endcase
        end

        // Data phase: register writes
        if (s.dp_sel && s.dp_wr) begin
            unique case (s.dp_addr)
                sms_pkg::ADDR_CTRL: begin
                    next_s.enable = hwdata_i[sms_pkg::CTRL_EN_BIT];
                    next_s.master = hwdata_i[sms_pkg::CTRL_MST_BIT];
                    next_s.lsbf = hwdata_i[sms_pkg::CTRL_LSB_BIT];
                    next_s.rate = hwdata_i[sms_pkg::CTRL_RATE_LSB +: 3];
                end
                sms_pkg::ADDR_STATUS: w1c = hwdata_i[1:0];
                sms_pkg::ADDR_MASK: next_s.mask = hwdata_i[1:0];
                default: w1c = 2'h0;
            endcase
        end

        // Shift engine
        unique case (s.phase)
            sms_pkg::ST_IDLE: begin
                next_s.bitcnt = 3'h0;
                next_s.divcnt = 7'h00;
                if (!s.enable) begin
                    // Port off: every pin released
                    next_s.pins.sck_oe_n = 1'b1;
                    next_s.pins.mosi_oe_n = 1'b1;
                    next_s.pins.miso_oe_n = 1'b1;
                    if (wr_data) begin
                        next_s.shreg = hwdata_i[7:0];
                    end
                end else if (s.master) begin
                    // master drives SCK and MOSI, MISO input
                    next_s.pins.sck_oe_n = 1'b0;
                    next_s.pins.mosi_oe_n = 1'b0;
                    next_s.pins.miso_oe_n = 1'b1;
                    next_s.pins.sck_o = 1'b0;
                    if (wr_data) begin
                        next_s.shreg = hwdata_i[7:0];
                        next_s.pins.mosi_o = out_bit(hwdata_i[7:0], s.lsbf);
                        next_s.phase = sms_pkg::ST_MASTER;
                    end
                end else begin
                    next_s.pins.sck_oe_n = 1'b1;
                    next_s.pins.mosi_oe_n = 1'b1;
                    next_s.pins.miso_oe_n = ss_n;
                    nb = wr_data ? hwdata_i[7:0] : s.shreg;
                    // loads allowed, no shifting while deselected
                    next_s.shreg = nb;
                    next_s.pins.miso_o = out_bit(nb, s.lsbf);
                    if (!ss_n) begin
                        next_s.phase = sms_pkg::ST_SLAVE;
                    end
                end
            end
            sms_pkg::ST_MASTER: begin
                coll_ev = wr_data;
                if (!s.enable || !s.master) begin
                    next_s.phase = sms_pkg::ST_IDLE;
                    next_s.pins.sck_o = 1'b0;
                    next_s.bitcnt = 3'h0;
                end else if (s.divcnt >= half_period(s.rate) - 7'h01) begin
                    // half period is 1 to 64 core cycles
                    next_s.divcnt = 7'h00;
                    if (!s.pins.sck_o) begin
                        next_s.pins.sck_o = 1'b1;
                        next_s.samp = miso_in;
                    end else begin
                        next_s.pins.sck_o = 1'b0;
                        nb = shift_in(s.shreg, s.lsbf, s.samp);
                        next_s.shreg = nb;
                        next_s.pins.mosi_o = out_bit(nb, s.lsbf);
                        next_s.bitcnt = s.bitcnt + 3'h1;
                        if (s.bitcnt == sms_pkg::LAST_BIT) begin
                            done_ev = 1'b1;
                            next_s.bitcnt = 3'h0;
                            next_s.phase = sms_pkg::ST_IDLE;
                        end
                    end
                end else begin
                    next_s.divcnt = s.divcnt + 7'h01;
                end
            end
            sms_pkg::ST_SLAVE: begin
                if (ss_n || !s.enable || s.master) begin
                    // select high resets the bit counter
                    next_s.phase = sms_pkg::ST_IDLE;
                    next_s.bitcnt = 3'h0;
                    next_s.pins.miso_oe_n = 1'b1;
                end else begin
                    next_s.pins.miso_oe_n = 1'b0;
                    if (wr_data && (s.bitcnt != 3'h0 || sck_in)) begin
                        coll_ev = 1'b1;
                    end else if (wr_data) begin
                        next_s.shreg = hwdata_i[7:0];
                        next_s.pins.miso_o = out_bit(hwdata_i[7:0], s.lsbf);
                    end
                    if (sck_rise) begin
                        next_s.samp = mosi_in;
                    end
                    if (sck_fall) begin
                        nb = shift_in(s.shreg, s.lsbf, s.samp);
                        next_s.shreg = nb;
                        next_s.pins.miso_o = out_bit(nb, s.lsbf);
                        next_s.bitcnt = s.bitcnt + 3'h1;
                        done_ev = (s.bitcnt == sms_pkg::LAST_BIT);
                    end
                end
            end
            default: next_s.phase = sms_pkg::ST_IDLE;
        endcase

        // newest byte replaces an unread one
        if (done_ev) begin
            next_s.rx_buf = nb;
        end

        // Sticky flags; a new event beats a same-cycle clear
        next_s.status = (s.status & ~w1c) | {coll_ev, done_ev};
        // mask bit zero enables the done interrupt
        next_s.irq = |(next_s.status & next_s.mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    // Constant reset values only
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{sync1: sms_pkg::SYNC_RST, sync2: sms_pkg::SYNC_RST,
                   phase: sms_pkg::ST_IDLE, shreg: sms_pkg::BYTE_RST,
                   rx_buf: sms_pkg::BYTE_RST, rate: sms_pkg::RATE_RST,
                   hreadyout: 1'b1, dp_addr: 12'h000, hrdata: 32'h0000_0000,
                   pins: '{sck_oe_n: 1'b1, mosi_oe_n: 1'b1, miso_oe_n: 1'b1,
                           default: 1'b0},
                   default: '0};
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign hreadyout_o = s.hreadyout;
    assign hresp_o = s.hresp;
    assign hrdata_o = s.hrdata;
    assign irq_o = s.irq;
    assign sck_o = s.pins.sck_o;
    assign sck_oe_n_o = s.pins.sck_oe_n;
    assign mosi_o = s.pins.mosi_o;
    assign mosi_oe_n_o = s.pins.mosi_oe_n;
    assign miso_o = s.pins.miso_o;
    assign miso_oe_n_o = s.pins.miso_oe_n;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    master_start_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (s.phase == sms_pkg::ST_IDLE && s.enable && s.master && wr_data)
        |=> (s.phase == sms_pkg::ST_MASTER))
        else $error("Data write did not start master transfer");

    master_done_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (s.phase == sms_pkg::ST_MASTER && s.enable && s.master)
        ##1 (s.phase == sms_pkg::ST_IDLE) |-> s.status[sms_pkg::STAT_DONE_BIT])
        else $error("Master byte ended without done flag");

    irq_level_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (done_ev && next_s.mask[sms_pkg::STAT_DONE_BIT]) |=> irq_o)
        else $error("Done flag raised no enabled interrupt");

    rx_hold_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        !done_ev |=> $stable(s.rx_buf))
        else $error("Receive buffer changed without a byte");

    slave_release_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (!s.master && ss_n) |=> miso_oe_n_o)
        else $error("MISO driven while deselected");

    slave_still_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (s.enable && !s.master && ss_n) |=> (s.bitcnt == 3'h0))
        else $error("Slave counted bits while deselected");

    write_coll_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (s.phase == sms_pkg::ST_MASTER && wr_data)
        |=> s.status[sms_pkg::STAT_COLL_BIT])
        else $error("Busy write did not flag collision");

    fast_rate_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (s.phase == sms_pkg::ST_MASTER && s.enable && s.master && s.rate == 3'h0)
        |=> (sck_o != $past(sck_o)) || (s.phase == sms_pkg::ST_IDLE))
        else $error("Double speed clock did not toggle each cycle");

    pin_dir_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (s.phase == sms_pkg::ST_SLAVE) |-> (sck_oe_n_o && mosi_oe_n_o))
        else $error("Slave drives an input pin");

    master_pins_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (s.phase == sms_pkg::ST_MASTER) |-> (miso_oe_n_o && !sck_oe_n_o))
        else $error("Master pin directions wrong");

endmodule

//--- tb/sms_far.sv
// Purpose: Far-side serial device model, acting as slave or as master
// Assumes: Clock idles low, data sampled on rising and changed on falling
// Notes: Drives its own clock only inside xfer, selected or not; at one sixteenth of core
`timescale 1ns/1ns
module sms_far (
    input wire logic clk_i,
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic miso_i,
    input wire logic lsbf_i,
    output logic sck_o,
    output logic mosi_o,
    output logic miso_o,
    output logic ss_n_o
);
    logic [7:0] tx_byte; // Byte returned while acting as slave
    logic [7:0] rx_byte; // Byte captured while acting as slave
    logic driving; // High while this model owns the clock
    logic tx_bit; // Bit presented on the data-out line

    initial begin
        tx_byte = 8'h00;
        rx_byte = 8'h00;
        driving = 1'b0;
        sck_o = 1'b0;
        mosi_o = 1'b0;
        ss_n_o = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slave side: released line shows the inverse, so a stale value never passes
    assign tx_bit = lsbf_i ? tx_byte[0] : tx_byte[7];
    assign miso_o = ss_n_o ? ~tx_bit : tx_bit;

    always @(posedge sck_i) begin
        if (!driving && !ss_n_o) begin
            rx_byte <= lsbf_i ? {mosi_i, rx_byte[7:1]} : {rx_byte[6:0], mosi_i};
        end
    end

    always @(negedge sck_i) begin
        if (!driving && !ss_n_o) begin
            tx_byte <= lsbf_i ? {1'b0, tx_byte[7:1]} : {tx_byte[6:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // select set up before clocking
    task automatic select(input logic v);
        @(posedge clk_i);
        ss_n_o <= v;
        repeat (4) @(posedge clk_i);
    endtask

    // master clock well under a quarter of core
    task automatic xfer(input logic [7:0] b, output logic [7:0] r);
        driving = 1'b1;
        r = 8'h00;
        @(posedge clk_i);
        mosi_o <= lsbf_i ? b[0] : b[7];
        for (int i = 0; i < 8; i++) begin
            repeat (8) @(posedge clk_i);
            sck_o <= 1'b1;
            r = lsbf_i ? {miso_i, r[7:1]} : {r[6:0], miso_i};
            repeat (8) @(posedge clk_i);
            sck_o <= 1'b0;
            if (i < 7) begin
                mosi_o <= lsbf_i ? b[i + 1] : b[6 - i];
            end
        end
        @(posedge clk_i);
        // Idle data line toggles so no stale bit is mistaken for data
        mosi_o <= ~mosi_o;
        driving = 1'b0;
    endtask
endmodule

//--- tb/sms_port_test.sv
// Purpose: Self-checking bench for the serial port, both roles
// Assumes: Zero-wait register bus; far device modelled in sms_far
// Notes: Receive data checked only at rates where sampling is not stale
`timescale 1ns/1ns
module sms_port_test;
    logic core_clk = 1'b0; // 100 MHz core clock
    logic resetn = 1'b0; // Active-low reset
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [2:0] hsize = 3'h0; // Transfer size, driven by the bus task
    logic hreadyout, hresp, irq;
    logic [31:0] hrdata;
    logic sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
    logic f_sck, f_mosi, f_miso, ss_n, sck_w, mosi_w, miso_w;
    logic lsbf = 1'b0; // Bit order the far model uses
    int fail_count = 0;
    int total_checks = 0;
    int npulse = 0; // Rising clock edges seen from the port
    int hcnt = 0;
    int hi_len = 0; // Length of the last high clock phase
    logic sck_d = 1'b0;
    logic [7:0] exp_q[$]; // Reference receive-buffer history

    always #5 core_clk = ~core_clk;

    // Wire levels from the port's enables
    assign sck_w = sck_oe_n ? f_sck : sck_out;
    assign mosi_w = mosi_oe_n ? f_mosi : mosi_out;
    assign miso_w = miso_oe_n ? f_miso : miso_out;

    sms_port DUT (.core_clk_i(core_clk), .resetn_i(resetn), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
        .irq_o(irq), .sck_i(sck_w), .sck_o(sck_out), .sck_oe_n_o(sck_oe_n),
        .mosi_i(mosi_w), .mosi_o(mosi_out), .mosi_oe_n_o(mosi_oe_n), .miso_i(miso_w),
        .miso_o(miso_out), .miso_oe_n_o(miso_oe_n), .ss_n_i(ss_n));

    sms_far far (.clk_i(core_clk), .sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w),
        .lsbf_i(lsbf), .sck_o(f_sck), .mosi_o(f_mosi), .miso_o(f_miso), .ss_n_o(ss_n));

    ////////////////////////////////////////////////////////////////////////////
    // Pulse count and high-phase length of the port's own clock
    always @(posedge core_clk) begin
        sck_d <= sck_out;
        if (sck_out && !sck_d) begin
            npulse <= npulse + 1;
        end
        if (sck_out) begin
            hcnt <= hcnt + 1;
        end else begin
            if (hcnt != 0) begin
                hi_len <= hcnt;
            end
            hcnt <= 0;
        end
    end

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One single word transfer; waits bounded on ready in both phases
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {20'h0_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'h2;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        r = hrdata;
        chk({31'h0, hresp}, 32'h0000_0000);
        if (n >= 40) begin
            fail_count++;
            final_report();
        end
    endtask

    // Poll one status bit, bounded
    task automatic wait_flag(input int b);
        logic [31:0] s;
        int n;
        n = 0;
        s = 32'h0;
        while (s[b] !== 1'b1 && n < 1000) begin
            bus(1'b0, sms_pkg::ADDR_STATUS, 32'h0, s);
            n++;
        end
        if (n >= 1000) begin
            fail_count++;
            final_report();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        logic [7:0] tx;
        logic [7:0] got;
        logic lb;
        int p0;
        void'($urandom(77762));
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk({29'h0, sck_oe_n, mosi_oe_n, miso_oe_n}, 32'h0000_0007);
        // All-ones writes read back, plus one unmapped word
        bus(1'b1, sms_pkg::ADDR_CTRL, 32'hFFFF_FFFF, r);
        bus(1'b1, sms_pkg::ADDR_MASK, 32'hFFFF_FFFF, r);
        bus(1'b1, 12'h010, 32'hFFFF_FFFF, r);
        for (int a = 0; a < 5; a++) begin
            bus(1'b0, 12'(a * 4), 32'h0, r);
            chk(r, a == 0 ? 32'h0000_0077 : (a == 2 ? 32'h0000_0003 : 32'h0000_0000));
        end
        // Master role: every rate code, random bit order, masked on even codes
        for (int rt = 0; rt < 8; rt++) begin
            lb = 1'($urandom % 2);
            lsbf <= lb;
            tx = 8'($urandom);
            far.tx_byte = 8'($urandom);
            exp_q.push_back(far.tx_byte);
            bus(1'b1, sms_pkg::ADDR_MASK, {31'h0, 1'(rt % 2)}, r);
            bus(1'b1, sms_pkg::ADDR_CTRL, {25'h0, 3'(rt), 1'b0, lb, 2'b11}, r);
            far.select(1'b0);
            p0 = npulse;
            bus(1'b1, sms_pkg::ADDR_DATA, {24'h0, tx}, r);
            wait_flag(0);
            repeat (2) @(posedge core_clk);
            chk({24'h0, far.rx_byte}, {24'h0, tx});
            chk(32'(npulse - p0), 32'h0000_0008);
            chk(32'(hi_len), 32'(1 << (rt == 7 ? 6 : rt)));
            chk({31'h0, irq}, 32'(rt % 2));
            chk({28'h0, sck_oe_n, mosi_oe_n, miso_oe_n, sck_out}, 32'h0000_0002);
            bus(1'b0, sms_pkg::ADDR_DATA, 32'h0, r);
            if (rt >= 2) begin
                chk(r, {24'h0, exp_q[$]});
            end
            bus(1'b1, sms_pkg::ADDR_STATUS, 32'h0000_0001, r);
            bus(1'b0, sms_pkg::ADDR_STATUS, 32'h0, r);
            chk({r[30:0], irq}, 32'h0000_0000);
            far.select(1'b1);
        end
        // Second data write while a byte is shifting
        bus(1'b1, sms_pkg::ADDR_MASK, 32'h0000_0002, r);
        bus(1'b1, sms_pkg::ADDR_CTRL, 32'h0000_0023, r);
        lsbf <= 1'b0;
        far.select(1'b0);
        bus(1'b1, sms_pkg::ADDR_DATA, 32'h0000_00A5, r);
        bus(1'b1, sms_pkg::ADDR_DATA, 32'h0000_003C, r);
        wait_flag(0);
        chk({24'h0, far.rx_byte}, 32'h0000_00A5);
        bus(1'b0, sms_pkg::ADDR_STATUS, 32'h0, r);
        chk({r[30:0], irq}, 32'h0000_0007);
        bus(1'b1, sms_pkg::ADDR_STATUS, 32'h0000_0003, r);
        far.select(1'b1);
        // Slave role: clocks while deselected, then two bytes unread
        lb = 1'($urandom % 2);
        lsbf <= lb;
        bus(1'b1, sms_pkg::ADDR_MASK, 32'h0000_0001, r);
        bus(1'b1, sms_pkg::ADDR_CTRL, {29'h0, lb, 2'b01}, r);
        tx = 8'($urandom);
        bus(1'b1, sms_pkg::ADDR_DATA, {24'h0, tx}, r);
        far.xfer(8'hFF, got);
        chk({31'h0, miso_oe_n}, 32'h0000_0001);
        bus(1'b0, sms_pkg::ADDR_STATUS, 32'h0, r);
        chk(r, 32'h0000_0000);
        far.select(1'b0);
        for (int k = 0; k < 2; k++) begin
            exp_q.push_back(8'($urandom));
            far.xfer(exp_q[$], got);
            chk({24'h0, got}, {24'h0, tx});
            wait_flag(0);
            chk({30'h0, miso_oe_n, irq}, 32'h0000_0001);
            bus(1'b1, sms_pkg::ADDR_STATUS, 32'h0000_0001, r);
            tx = 8'($urandom);
            bus(1'b1, sms_pkg::ADDR_DATA, {24'h0, tx}, r);
        end
        far.select(1'b1);
        chk({31'h0, miso_oe_n}, 32'h0000_0001);
        bus(1'b0, sms_pkg::ADDR_DATA, 32'h0, r);
        chk(r, {24'h0, exp_q[$]});
        final_report();
    end
endmodule
